// ===== inc/ssp_consts.svh
// Field positions, frame lengths and reset values of the serial port
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH
`define SSP_LEN_CFG 6'h08
`define SSP_LEN_RBUF 6'h10
`define SSP_LEN_AREG 6'h18
`define SSP_CNT_SAT 6'h21
`define SSP_CNT_ONE 6'h01
`define SSP_A_OUTSEL_HI 23
`define SSP_A_OUTSEL_LO 22
`define SSP_A_WORD_MSB 21
`define SSP_C_GP_PORT 1
`define SSP_C_OPEN_DRAIN 0
`define SSP_R_MODE_MSB 15
`define SSP_R_MODE_LSB 13
`define SSP_R_DIV_MSB 12
`define SSP_SEL_REF 2'h3
`define SSP_SEL_VCO 2'h2
`define SSP_SEL_SOUT 2'h1
`define SSP_SEL_PORT 2'h0
`define SSP_MODE_XTAL_OFF 3'h0
`define SSP_MODE_XTAL_ON 3'h1
`define SSP_MODE_REF_THRU 3'h3
`define SSP_MODE_DIV_BASE 3'h4
`define SSP_CFG_RST 8'h00
`define SSP_AREG_RST 24'h40_0000
`define SSP_RDIV_RST 13'h0005
`define SSP_RMODE_RST 3'h6
`define SSP_RDIV_THRU 13'h0001
`endif

// ===== inc/ssp_pkg.sv
// Types shared by the serial port and its output logic
package ssp_pkg;
  typedef struct packed {
    logic [5:0] count;
    logic [23:0] bits;
  } ssp_frame_t;
  typedef struct packed {
    logic [2:0] refmode;
    logic [12:0] ref_divide_value;
  } ssp_rreg_t;
  typedef enum logic [1:0] {
    SSP_IDLE,
    SSP_SETTLE,
    SSP_COMMIT
  } ssp_commit_t;
endpackage : ssp_pkg

// ===== rtl/ssp_div.sv
// Tick divider: registered pulse once per limit ticks
`timescale 1ns/1ps
`default_nettype none
module ssp_div #(
  parameter int WIDTH = 13
) (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic clear, // Restart the count
  input wire logic tick, // One input event
  input wire logic [WIDTH-1:0] limit, // Ticks per output pulse
  output logic hit // One-cycle pulse at terminal count
);
  logic [WIDTH-1:0] count_ff;
  logic hit_ff;
  wire last_tick = (count_ff >= limit - WIDTH'(1));

  generate
    if (WIDTH < 2) begin : g_bad
      $error("ssp_div width must be at least two");
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst || clear) begin
      count_ff <= '0;
      hit_ff <= 1'b0;
    end else begin
      hit_ff <= tick && last_tick;
      if (tick) begin
        count_ff <= last_tick ? '0 : count_ff + WIDTH'(1);
      end
    end
  end
  assign hit = hit_ff;
endmodule : ssp_div
`default_nettype wire

// ===== rtl/ssp_sync.sv
// Two-stage synchroniser for asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module ssp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk, // Destination clock
  input wire logic rst, // Synchronous reset
  input wire logic [WIDTH-1:0] async_in, // Asynchronous levels
  output logic [WIDTH-1:0] sync_out // Synchronised levels
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  generate
    if (WIDTH < 1) begin : g_bad
      $error("ssp_sync width must be at least one");
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end
  assign sync_out = sync_ff;
endmodule : ssp_sync
`default_nettype wire

// ===== rtl/ssp_top.sv
// Serial load port, output selection and reference pin control
// Notes on behaviour
// - Enable high: shifting ignored, port held initialised.
// - Enable rising edge copies shifted bits to the selected register.
// - 8 bits load config, 16 the first R buffer, 24 the A register.
// - Data is MSB first, sampled on shift clock rising edges.
// - R divide value moves to second buffer on A load or clockless pulse.
// - Enable high with shift clock low resynchronises the port.
// - Two top A bits pick output A: reference, VCO, serial out, port.
// - Reference mode on output A is normally low with high pulses.
// - Reference counter divides by its 13-bit value; value 1 passes through.
// - VCO mode on output A carries the divided VCO pulses.
// - Serial out is the half stage, updated on shift clock falling edges.
// - Output A starts in serial-out mode.
// - Port mode drives output A with the general port bit.
// - Open-drain output pulls low for bit 0, floats for bit 1.
// - Reset forces the open-drain output low.
// - Mode 001 runs the oscillator; counter divides unless in standby.
// - Standby with oscillator on keeps it running, counter halted.
// - Mode 0 stops the oscillator, standby or not.
// - External reference modes divide onto reference output; 7 is 16, 3 is 1:1.
// - Reference output divider starts at a ratio of eight.
`timescale 1ns/1ps
`default_nettype none
`include "ssp_consts.svh"
module ssp_top #(
  parameter int DIV_WIDTH = 13
) (
  input wire logic clk, // System clock
  input wire logic rst, // Reset, active high; synchronous in the system domain, asynchronous for the link-domain flops except armed_ff, which only enable high sets
  input wire logic shift_clk, // Serial shift clock from the host
  input wire logic frame_enable_n, // Frame enable, active low
  input wire logic serial_data_in, // Serial data, MSB first
  input wire logic reference_input, // Reference pin level
  input wire logic standby, // Standby request, same clock
  input wire logic divided_vco, // N counter pulses, same clock
  output logic output_a, // Multi-function output
  output logic open_drain_out, // Open-drain level, always low
  output logic open_drain_oe_n, // Open-drain enable, low drives
  output logic reference_output, // Divided reference output
  output logic osc_enable, // Crystal oscillator run
  output logic ref_to_detector, // Divided reference to detectors
  output logic [21:0] counter_word, // N and A counter values
  output logic [DIV_WIDTH-1:0] ref_divide_value // Active R divide value
);
  generate
    if (DIV_WIDTH != 13) begin : g_bad
      $error("ssp_top reference divider must be 13 bits");
    end
  endgenerate

  // Link domain: shift register, bit count, frame marker
  logic armed_ff;
  logic [23:0] shift_ff;
  logic [5:0] cnt_ff;
  logic frame_tog_ff;
  logic half_ff;
  wire [5:0] nxt_cnt = armed_ff ? `SSP_CNT_ONE :
    (cnt_ff == `SSP_CNT_SAT) ? cnt_ff : cnt_ff + 6'h01;

  // Enable high re-arms at once, whatever the shift clock did
  always_ff @(posedge shift_clk or posedge frame_enable_n) begin
    if (frame_enable_n) begin
      armed_ff <= 1'b1;
    end else begin
      armed_ff <= 1'b0;
    end
  end

  always_ff @(posedge shift_clk or posedge rst) begin
    if (rst) begin
      shift_ff <= '0;
      cnt_ff <= '0;
      frame_tog_ff <= 1'b0;
    end else if (!frame_enable_n) begin
      shift_ff <= {shift_ff[22:0], serial_data_in};
      cnt_ff <= nxt_cnt;
      if (armed_ff) begin
        frame_tog_ff <= ~frame_tog_ff;
      end
    end
  end

  always_ff @(negedge shift_clk or posedge rst) begin
    if (rst) begin
      half_ff <= 1'b0;
    end else begin
      half_ff <= shift_ff[23];
    end
  end

  // System domain: synchronised link and pin levels
  logic [3:0] sync_lvl;
  // Enable crosses inverted so the synchroniser's reset value is the idle level
  wire enb_s = !sync_lvl[0];
  wire tog_s = sync_lvl[1];
  wire sout_s = sync_lvl[2];
  wire ref_s = sync_lvl[3];

  ssp_sync #(.WIDTH(4)) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in({reference_input, half_ff, frame_tog_ff, !frame_enable_n}),
    .sync_out(sync_lvl)
  );

  logic enb_prev_ff;
  logic seen_tog_ff;
  logic ref_prev_ff;
  ssp_pkg::ssp_commit_t state_ff;
  ssp_pkg::ssp_commit_t nxt_state;
  logic [7:0] cfg_ff;
  logic [23:0] areg_ff;
  logic [12:0] rbuf1_ff;
  logic [12:0] rbuf2_ff;
  logic [2:0] refmode_ff;
  logic out_a_ff;
  logic od_oe_n_ff;
  logic reference_output_ff;
  logic osc_ff;
  logic fr_ff;

  wire enb_rise = enb_s && !enb_prev_ff;
  wire ref_tick = ref_s && !ref_prev_ff;
  wire commit = (state_ff == ssp_pkg::SSP_COMMIT);
  wire clocked = (tog_s != seen_tog_ff);
  // Link flops are static here: enable is high and the clock idle
  ssp_pkg::ssp_frame_t frame;
  assign frame = '{count: cnt_ff, bits: shift_ff};
  wire len_cfg = (frame.count == `SSP_LEN_CFG);
  wire len_rbuf = (frame.count == `SSP_LEN_RBUF);
  wire len_areg = (frame.count == `SSP_LEN_AREG);
  ssp_pkg::ssp_rreg_t rword;
  assign rword = frame.bits[15:0];
  wire [1:0] outsel = areg_ff[`SSP_A_OUTSEL_HI:`SSP_A_OUTSEL_LO];

  // Settle state gives the frame marker time to cross first
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ssp_pkg::SSP_IDLE: nxt_state = enb_rise ? ssp_pkg::SSP_SETTLE : ssp_pkg::SSP_IDLE;
      ssp_pkg::SSP_SETTLE: nxt_state = ssp_pkg::SSP_COMMIT;
      ssp_pkg::SSP_COMMIT: nxt_state = ssp_pkg::SSP_IDLE;
      default: nxt_state = ssp_pkg::SSP_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= ssp_pkg::SSP_IDLE;
      enb_prev_ff <= 1'b1;
      seen_tog_ff <= 1'b0;
      ref_prev_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      enb_prev_ff <= enb_s;
      ref_prev_ff <= ref_s;
      if (commit) begin
        seen_tog_ff <= tog_s;
      end
    end
  end

  // Register loads at the end of a frame
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_ff <= `SSP_CFG_RST;
      areg_ff <= `SSP_AREG_RST;
      rbuf1_ff <= `SSP_RDIV_RST;
      rbuf2_ff <= `SSP_RDIV_RST;
      refmode_ff <= `SSP_RMODE_RST;
    end else if (commit && clocked) begin
      if (len_cfg) begin
        cfg_ff <= frame.bits[7:0];
      end
      if (len_rbuf) begin
        rbuf1_ff <= rword.ref_divide_value;
        refmode_ff <= rword.refmode;
      end
      if (len_areg) begin
        areg_ff <= frame.bits;
        rbuf2_ff <= rbuf1_ff;
      end
    end else if (commit) begin
      rbuf2_ff <= rbuf1_ff;
    end
  end

  // Reference counter and reference output divider
  wire ref_run = (refmode_ff != `SSP_MODE_XTAL_OFF) && !standby;
  wire ref_hit;
  wire reference_output_hit;
  wire ref_thru = (rbuf2_ff == `SSP_RDIV_THRU);
  wire ref_div_mode = (refmode_ff >= `SSP_MODE_DIV_BASE);
  wire [1:0] ratio_exp = refmode_ff[1:0];
  wire [3:0] reference_output_half = 4'h1 << ratio_exp;

  ssp_div #(.WIDTH(13)) u_rdiv (
    .clk(clk),
    .rst(rst),
    .clear(!ref_run),
    .tick(ref_tick),
    .limit(rbuf2_ff),
    .hit(ref_hit)
  );

  ssp_div #(.WIDTH(4)) u_odiv (
    .clk(clk),
    .rst(rst),
    .clear(!ref_div_mode),
    .tick(ref_tick),
    .limit(reference_output_half),
    .hit(reference_output_hit)
  );

  wire fr_next = ref_thru ? (ref_s && ref_run) : ref_hit;
  wire reference_output_next = (refmode_ff == `SSP_MODE_REF_THRU) ? ref_s :
    ref_div_mode ? (reference_output_ff ^ reference_output_hit) : 1'b0;

  logic out_a_next;
  always_comb begin
    case (outsel)
      `SSP_SEL_REF: out_a_next = fr_ff;
      `SSP_SEL_VCO: out_a_next = divided_vco;
      `SSP_SEL_SOUT: out_a_next = sout_s;
      `SSP_SEL_PORT: out_a_next = cfg_ff[`SSP_C_GP_PORT];
      default: out_a_next = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fr_ff <= 1'b0;
      reference_output_ff <= 1'b0;
      osc_ff <= 1'b0;
      out_a_ff <= 1'b0;
      od_oe_n_ff <= 1'b0;
    end else begin
      fr_ff <= fr_next;
      reference_output_ff <= reference_output_next;
      osc_ff <= (refmode_ff == `SSP_MODE_XTAL_ON);
      out_a_ff <= out_a_next;
      od_oe_n_ff <= cfg_ff[`SSP_C_OPEN_DRAIN];
    end
  end

  assign output_a = out_a_ff;
  assign open_drain_out = 1'b0;
  assign open_drain_oe_n = od_oe_n_ff;
  assign reference_output = reference_output_ff;
  assign osc_enable = osc_ff;
  assign ref_to_detector = fr_ff;
  assign counter_word = areg_ff[`SSP_A_WORD_MSB:0];
  assign ref_divide_value = rbuf2_ff;

  // Checks on the frame sequence and output control
  sequence s_frame_end;
    enb_rise ##1 (state_ff == ssp_pkg::SSP_SETTLE);
  endsequence

  sequence s_commit_follows;
    ##1 commit;
  endsequence

  a_frame_commit_timing: assert property (@(posedge clk) disable iff (rst)
    s_frame_end |-> s_commit_follows)
    else $error("commit did not follow enable rise");

  a_cfg_frame_load: assert property (@(posedge clk) disable iff (rst)
    commit && clocked && len_cfg |=> cfg_ff == $past(shift_ff[7:0]))
    else $error("config register not loaded by 8-bit frame");

  a_odd_frame_ignored: assert property (@(posedge clk) disable iff (rst)
    commit && clocked && !len_cfg && !len_rbuf && !len_areg
    |=> $stable(cfg_ff) && $stable(areg_ff) && $stable(rbuf1_ff) && $stable(refmode_ff))
    else $error("odd-length frame changed a register");

  a_rbuf_transfer: assert property (@(posedge clk) disable iff (rst)
    commit && (!clocked || len_areg) |=> rbuf2_ff == $past(rbuf1_ff))
    else $error("second R buffer not loaded");

  a_port_mode_out: assert property (@(posedge clk) disable iff (rst)
    outsel == `SSP_SEL_PORT && $stable(outsel) |=> output_a == $past(cfg_ff[1]))
    else $error("port mode output mismatch");

  a_reset_defaults: assert property (@(posedge clk)
    rst |=> outsel == `SSP_SEL_SOUT && !open_drain_oe_n && refmode_ff == `SSP_RMODE_RST)
    else $error("reset defaults wrong");

  a_osc_stop_mode: assert property (@(posedge clk) disable iff (rst)
    refmode_ff == `SSP_MODE_XTAL_OFF |=> !osc_enable)
    else $error("oscillator runs in mode zero");

  a_standby_halts_ref: assert property (@(posedge clk) disable iff (rst)
    standby [*3] |-> !ref_hit)
    else $error("reference counter runs in standby");

  a_shift_msb_first: assert property (@(posedge shift_clk) disable iff (rst)
    !frame_enable_n |=> shift_ff[0] == $past(serial_data_in))
    else $error("serial bit not shifted in");

  a_count_restarts: assert property (@(posedge shift_clk) disable iff (rst)
    !frame_enable_n && armed_ff |=> cnt_ff == `SSP_CNT_ONE)
    else $error("bit count not restarted at frame start");
endmodule : ssp_top
`default_nettype wire

// ===== verification/ssp_host_model.sv
// Host side of the serial load port: frame master at the link rate
`timescale 1ns/1ps
`default_nettype none
module ssp_host_model (
  output logic shift_clk, // Shift clock, stands low outside frames
  output logic frame_enable_n, // Frame enable, active low
  output logic serial_data_in // Serial data to the port
);
  initial begin
    shift_clk = 1'b0;
    frame_enable_n = 1'b1;
    serial_data_in = 1'b0;
  end
  // A count of 0 gives the clockless enable pulse
  task automatic send(input int n, input logic [31:0] w);
    frame_enable_n = 1'b0;
    #62.5;
    for (int i = n - 1; i >= 0; i--) begin
      serial_data_in = w[i];
      #62.5 shift_clk = 1'b1;
      #62.5 shift_clk = 1'b0;
    end
    #62.5 frame_enable_n = 1'b1;
    // Released line must not keep the last bit
    serial_data_in = ~serial_data_in;
    #700;
  endtask : send
endmodule : ssp_host_model
`default_nettype wire

// ===== verification/ssp_top_tb.sv
// Self-checking bench for the serial port and output control
`timescale 1ns/1ps
`default_nettype none
module ssp_top_tb;
  logic clk, rst, shift_clk, frame_enable_n, serial_data_in;
  logic reference_input, standby, divided_vco;
  logic output_a, open_drain_out, open_drain_oe_n, reference_output, osc_enable, ref_to_detector;
  logic [21:0] counter_word;
  logic [12:0] ref_divide_value, prev_div;
  logic det_q, out_q, a_q;
  int miscompares, samples_checked, cnt_det, cnt_out, cnt_a;
  // R frame, detector pulses and output changes per 40 input periods, oscillator
  logic [15:0] rw [6] = '{16'h6004, 16'he005, 16'h8008, 16'h4005, 16'h0005, 16'h2001};
  int ed [6] = '{10, 8, 5, 8, 0, 40};
  int eo [6] = '{80, 5, 40, 0, 0, 0};
  logic eos [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};

  ssp_top ssp_top_i (.clk(clk), .rst(rst), .shift_clk(shift_clk),
    .frame_enable_n(frame_enable_n), .serial_data_in(serial_data_in),
    .reference_input(reference_input), .standby(standby), .divided_vco(divided_vco),
    .output_a(output_a), .open_drain_out(open_drain_out), .open_drain_oe_n(open_drain_oe_n),
    .reference_output(reference_output), .osc_enable(osc_enable),
    .ref_to_detector(ref_to_detector), .counter_word(counter_word),
    .ref_divide_value(ref_divide_value));
  ssp_host_model ssp_host_model_i (.shift_clk(shift_clk), .frame_enable_n(frame_enable_n),
    .serial_data_in(serial_data_in));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    det_q <= ref_to_detector;
    out_q <= reference_output;
    a_q <= output_a;
    if (ref_to_detector === 1'b1 && det_q === 1'b0) cnt_det++;
    if (reference_output !== out_q) cnt_out++;
    if (output_a === 1'b1 && a_q === 1'b0) cnt_a++;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic frame(input int n, input logic [31:0] w);
    ssp_host_model_i.send(n, w);
    repeat (10) @(negedge clk);
  endtask : frame

  // Leaves the input low long enough for every pulse to land in its window
  task automatic ref_run(input int n);
    cnt_det = 0;
    cnt_out = 0;
    cnt_a = 0;
    repeat (n) begin
      reference_input = 1'b1;
      repeat (2) @(negedge clk);
      reference_input = 1'b0;
      repeat (2) @(negedge clk);
    end
    repeat (8) @(negedge clk);
  endtask : ref_run

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    #3000000;
    miscompares++;
    finish_test();
  end

  initial begin
    rst = 1'b1;
    reference_input = 1'b0;
    standby = 1'b0;
    divided_vco = 1'b0;
    det_q = 1'b0;
    out_q = 1'b0;
    a_q = 1'b0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check("oe_n_rst", open_drain_oe_n, 32'h0);
    check("od_level", open_drain_out, 32'h0);
    check("rdiv_rst", ref_divide_value, 32'h5);
    check("word_rst", counter_word, 32'h0);
    check("osc_rst", osc_enable, 32'h0);
    check("out_a_rst", output_a, 32'h0);
    ref_run(40);
    check("det_rst", cnt_det, 32'd8);
    check("reference_output_rst", cnt_out, 32'd10);
    // Overlong frame: no load, but the half stage carries the final top bit, the ninth bit sent
    frame(32, 32'h0080_0000);
    check("sout", output_a, 32'h1);
    check("word_long", counter_word, 32'h0);
    check("oe_n_long", open_drain_oe_n, 32'h0);
    frame(24, 32'h0012_3456);
    check("word", counter_word, 32'h12_3456);
    check("port0", output_a, 32'h0);
    frame(8, 32'h02);
    check("port1", output_a, 32'h1);
    check("oe_n_c2", open_drain_oe_n, 32'h0);
    frame(8, 32'h01);
    check("port_c1", output_a, 32'h0);
    check("oe_n_c1", open_drain_oe_n, 32'h1);
    frame(24, 32'h00c0_0000);
    check("word_ref", counter_word, 32'h0);
    prev_div = 13'h0005;
    for (int i = 0; i < 6; i++) begin
      frame(16, {16'h0000, rw[i]});
      check("rdiv_held", ref_divide_value, prev_div);
      check("osc", osc_enable, eos[i]);
      frame(0, 32'h0);
      check("rdiv", ref_divide_value, rw[i][12:0]);
      prev_div = rw[i][12:0];
      ref_run(40);
      check("det", cnt_det, ed[i]);
      check("reference_output", cnt_out, eo[i]);
      check("out_a_ref", cnt_a, ed[i]);
    end
    standby = 1'b1;
    ref_run(10);
    check("det_stby", cnt_det, 32'd0);
    check("osc_stby", osc_enable, 32'h1);
    standby = 1'b0;
    frame(24, 32'h0080_0000);
    frame(24, 32'h0080_0000);
    cnt_a = 0;
    repeat (6) begin
      divided_vco = 1'b1;
      @(negedge clk);
      divided_vco = 1'b0;
      repeat (3) @(negedge clk);
    end
    repeat (8) @(negedge clk);
    check("out_a_vco", cnt_a, 32'd6);
    finish_test();
  end
endmodule : ssp_top_tb
`default_nettype wire
